/* core_regs_pkg.sv */
// Shared constants and carrier types for the core special register block.
// Assumes one 10 MHz clock and a classic Wishbone register port.
package core_regs_pkg;

	// ********************************
	// Register addresses (byte offsets)
	// ********************************
	localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
	localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
	localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
	localparam logic [7:0] ADDR_STATUS = 8'hd0;
	localparam logic [7:0] ADDR_MAIN_OP = 8'he0;
	localparam logic [7:0] ADDR_AUX = 8'hf0;
	localparam logic [7:0] ADDR_COUNTER_LOW = 8'hf8;
	localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hf9;
	localparam logic [7:0] ADDR_OP_CTRL = 8'hfa;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [7:0] STACK_RESET = 8'h07;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MAIN_RESET = 8'h00;
	localparam logic [7:0] AUX_RESET = 8'h00;
	localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;

	// ********************************
	// Status word bit positions, half-sum carry bit and bank shift
	// ********************************
	localparam int BIT_CARRY = 7;
	localparam int BIT_HALF = 6;
	localparam int BIT_USER0 = 5;
	localparam int BIT_BANK_HI = 4;
	localparam int BIT_BANK_LO = 3;
	localparam int BIT_EXCESS = 2;
	localparam int BIT_USER1 = 1;
	localparam int BIT_PARITY = 0;
	localparam int HALF_BIT = 4;
	localparam logic [7:0] BANK_SIZE_SHIFT = 8'h03;

	// ********************************
	// Operation codes in the control register
	// ********************************
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADD = 3'h1,
		OP_SUB = 3'h2,
		OP_PRODUCT = 3'h3,
		OP_DIVIDE = 3'h4,
		OP_DATA_POINTER_INC = 3'h5,
		OP_PUSH = 3'h6,
		OP_STEP = 3'h7
	} op_code_t;

	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] dat;
		logic we;
		logic sel;
	} bus_req_t;

endpackage

/* core_status_regs.sv */
// Core special registers: counter, operand pair, stack, status word, data pointer.
// Assumes a classic Wishbone master on 8-bit data; operations come by register write.
//
// Operation
// - Instruction counter is 16 bits and resets to zero.
// - Product: unsigned main times aux, low byte to main, high to aux.
// - Divide: main over aux, quotient to main, remainder to aux.
// - Stack pointer is 8 bits, resets to 07h, pushes grow upward.
// - Carry set on carry out of bit 7 or borrow into it.
// - Half carry set on carry out of bit 3 or borrow into it.
// - Parity bit shows odd parity of the main register, live on d0h reads and one edge later on o_status_word.
// - Status word at d0h, all bits readable, bits 7..1 writable (parity is hardware-owned), reset to zero.
// - Data pointer is 16 bits from bytes at 82h and 83h.
// - Aux register at f0h also serves as plain read/write storage.
`timescale 1ns/1ps

module core_status_regs
	import core_regs_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [7:0] i_wb_dat,
	input wire logic i_wb_sel,
	output logic [7:0] o_wb_dat,
	output logic o_wb_ack,
	output logic [15:0] o_instr_counter,
	output logic [7:0] o_bank_base,
	output logic [7:0] o_stack_top_ptr,
	output logic [15:0] o_data_pointer,
	output logic [7:0] o_status_word
);

	// ********************************
	// State
	// ********************************
	logic [15:0] instr_counter_r;
	logic [7:0] main_operand_reg_r;
	logic [7:0] aux_mul_div_reg_r;
	logic [7:0] stack_top_ptr_r;
	logic [7:0] status_r;
	logic [15:0] data_pointer_r;
	logic ack_r;
	logic [7:0] rdat_r;
	bus_req_t req;

	assign req = '{adr: i_wb_adr, dat: i_wb_dat, we: i_wb_we, sel: i_wb_sel};

	// ********************************
	// Bus decode
	// ********************************
	// Writes take effect on the edge that raises ack, so one write per access.
	wire access = i_wb_cyc && i_wb_stb && !ack_r;
	wire wr = access && req.we && req.sel;
	wire wr_main = wr && (req.adr == ADDR_MAIN_OP);
	wire wr_aux = wr && (req.adr == ADDR_AUX);
	wire wr_stack = wr && (req.adr == ADDR_STACK_TOP);
	wire wr_status = wr && (req.adr == ADDR_STATUS);
	wire wr_dpl = wr && (req.adr == ADDR_DATA_POINTER_LOW);
	wire wr_dph = wr && (req.adr == ADDR_DATA_POINTER_HIGH);
	wire wr_pcl = wr && (req.adr == ADDR_COUNTER_LOW);
	wire wr_pch = wr && (req.adr == ADDR_COUNTER_HIGH);
	wire wr_op = wr && (req.adr == ADDR_OP_CTRL);
	wire op_code_t op = wr_op ? op_code_t'(req.dat[2:0]) : OP_NONE;

	// ********************************
	// Arithmetic
	// ********************************
	wire parity = ^main_operand_reg_r;
	wire [15:0] product = 16'(main_operand_reg_r) * 16'(aux_mul_div_reg_r);
	wire div_zero = (aux_mul_div_reg_r == 8'h00);
	wire [7:0] quot = div_zero ? 8'hff : main_operand_reg_r / aux_mul_div_reg_r;
	wire [7:0] rem = div_zero ? main_operand_reg_r : main_operand_reg_r % aux_mul_div_reg_r;
	wire sub = (op == OP_SUB);
	wire [7:0] opnd = sub ? ~aux_mul_div_reg_r : aux_mul_div_reg_r;
	wire cin = sub ? !status_r[BIT_CARRY] : status_r[BIT_CARRY];
	wire [8:0] full_sum = 9'(main_operand_reg_r) + 9'(opnd) + 9'(cin);
	wire [4:0] low_sum = 5'(main_operand_reg_r[3:0]) + 5'(opnd[3:0]) + 5'(cin);
	// Borrow is the inverted carry of the complemented add
	wire carry_out = sub ? !full_sum[8] : full_sum[8];
	wire half_out = sub ? !low_sum[HALF_BIT] : low_sum[HALF_BIT];
	wire excess = (main_operand_reg_r[7] == opnd[7]) && (full_sum[7] != opnd[7]);
	wire [7:0] bank_sel = 8'({status_r[BIT_BANK_HI], status_r[BIT_BANK_LO]});
	wire [7:0] bank_base = bank_sel << BANK_SIZE_SHIFT;

	// ********************************
	// Next values
	// ********************************
	logic [7:0] main_nxt;
	logic [7:0] aux_nxt;
	logic [7:0] status_nxt;
	always_comb begin
		main_nxt = main_operand_reg_r;
		aux_nxt = aux_mul_div_reg_r;
		status_nxt = status_r;
		if (wr_main)
			main_nxt = req.dat;
		if (wr_aux)
			aux_nxt = req.dat;
		if (wr_status)
			status_nxt = req.dat;
		case (op)
			OP_ADD, OP_SUB: begin
				main_nxt = full_sum[7:0];
				status_nxt[BIT_CARRY] = carry_out;
				status_nxt[BIT_HALF] = half_out;
				status_nxt[BIT_EXCESS] = excess;
			end
			OP_PRODUCT: begin
				main_nxt = product[7:0];
				aux_nxt = product[15:8];
				status_nxt[BIT_CARRY] = 1'b0;
				status_nxt[BIT_EXCESS] = (product[15:8] != 8'h00);
			end
			OP_DIVIDE: begin
				main_nxt = quot;
				aux_nxt = rem;
				status_nxt[BIT_CARRY] = 1'b0;
				status_nxt[BIT_EXCESS] = div_zero;
			end
			default: begin
			end
		endcase
		// Parity is hardware-owned; a software write to it is overridden
		status_nxt[BIT_PARITY] = ^main_nxt;
	end

	// ********************************
	// Read mux
	// ********************************
	logic [7:0] rd_mux;
	always_comb begin
		case (req.adr)
			ADDR_MAIN_OP: rd_mux = main_operand_reg_r;
			ADDR_AUX: rd_mux = aux_mul_div_reg_r;
			ADDR_STACK_TOP: rd_mux = stack_top_ptr_r;
			ADDR_STATUS: rd_mux = {status_r[7:1], parity};
			ADDR_DATA_POINTER_LOW: rd_mux = data_pointer_r[7:0];
			ADDR_DATA_POINTER_HIGH: rd_mux = data_pointer_r[15:8];
			ADDR_COUNTER_LOW: rd_mux = instr_counter_r[7:0];
			ADDR_COUNTER_HIGH: rd_mux = instr_counter_r[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			main_operand_reg_r <= MAIN_RESET;
			aux_mul_div_reg_r <= AUX_RESET;
			status_r <= STATUS_RESET;
		end else begin
			main_operand_reg_r <= main_nxt;
			aux_mul_div_reg_r <= aux_nxt;
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			instr_counter_r <= COUNTER_RESET;
		end else if (wr_pcl) begin
			instr_counter_r[7:0] <= req.dat;
		end else if (wr_pch) begin
			instr_counter_r[15:8] <= req.dat;
		end else if (op == OP_STEP) begin
			instr_counter_r <= instr_counter_r + 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			stack_top_ptr_r <= STACK_RESET;
		end else if (wr_stack) begin
			stack_top_ptr_r <= req.dat;
		end else if (op == OP_PUSH) begin
			stack_top_ptr_r <= stack_top_ptr_r + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			data_pointer_r <= DATA_POINTER_RESET;
		end else if (wr_dpl) begin
			data_pointer_r[7:0] <= req.dat;
		end else if (wr_dph) begin
			data_pointer_r[15:8] <= req.dat;
		end else if (op == OP_DATA_POINTER_INC) begin
			data_pointer_r <= data_pointer_r + 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ack_r <= 1'b0;
			rdat_r <= 8'h00;
		end else begin
			ack_r <= access;
			rdat_r <= access ? rd_mux : rdat_r;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_bank_base <= 8'h00;
			o_status_word <= STATUS_RESET;
		end else begin
			o_bank_base <= bank_base;
			o_status_word <= {status_r[7:1], parity};
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;
	assign o_instr_counter = instr_counter_r;
	assign o_stack_top_ptr = stack_top_ptr_r;
	assign o_data_pointer = data_pointer_r;

	// ********************************
	// Checks
	// ********************************
	// Each operation is a one-cycle request whose result shows one edge later
	sequence s_add_req;
		op == OP_ADD;
	endsequence

	sequence s_sub_req;
		op == OP_SUB;
	endsequence

	sequence s_product_req;
		op == OP_PRODUCT;
	endsequence

	sequence s_divide_req;
		op == OP_DIVIDE && !div_zero;
	endsequence

	sequence s_div_zero_req;
		op == OP_DIVIDE && div_zero;
	endsequence

	sequence s_push_req;
		op == OP_PUSH;
	endsequence

	sequence s_step_req;
		op == OP_STEP;
	endsequence

	sequence s_data_pointer_inc_req;
		op == OP_DATA_POINTER_INC;
	endsequence

	a_counter_reset: assert property (
		@(posedge i_core_clk) $fell(i_reset) |-> o_instr_counter == COUNTER_RESET
	) else $error("counter not zero after reset");

	a_counter_step: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_step_req |=> o_instr_counter == $past(o_instr_counter) + 16'h0001
	) else $error("counter step wrong");

	a_product_split: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_product_req |=> {aux_mul_div_reg_r, main_operand_reg_r} == $past(product)
	) else $error("product split wrong");

	a_product_excess: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_product_req |=> status_r[BIT_EXCESS] == (aux_mul_div_reg_r != 8'h00)
	) else $error("product overflow flag wrong");

	a_divide_result: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_divide_req |=> (main_operand_reg_r * $past(aux_mul_div_reg_r)
			+ aux_mul_div_reg_r == $past(main_operand_reg_r))
	) else $error("divide wrong");

	a_divide_rem: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_divide_req |=> aux_mul_div_reg_r < $past(aux_mul_div_reg_r)
	) else $error("remainder not below divisor");

	a_stack_reset: assert property (
		@(posedge i_core_clk) $fell(i_reset) |-> o_stack_top_ptr == STACK_RESET
	) else $error("stack not 07h");

	a_stack_push: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_push_req |=> o_stack_top_ptr == $past(o_stack_top_ptr) + 8'h01
	) else $error("push does not grow upward");

	a_bank_base: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		##1 o_bank_base == 8'($past(status_r[BIT_BANK_HI:BIT_BANK_LO])) * 8'h08
	) else $error("bank base wrong");

	a_carry_add: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_add_req |=> status_r[BIT_CARRY] == ($past(main_operand_reg_r)
			+ $past(aux_mul_div_reg_r) + 9'($past(status_r[BIT_CARRY])) > 9'h0ff)
	) else $error("carry wrong");

	a_carry_sub: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_sub_req |=> status_r[BIT_CARRY] == (9'($past(main_operand_reg_r))
			< 9'($past(aux_mul_div_reg_r)) + 9'($past(status_r[BIT_CARRY])))
	) else $error("borrow wrong");

	a_half_carry: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_add_req |=> status_r[BIT_HALF] == ($past(main_operand_reg_r[3:0])
			+ $past(aux_mul_div_reg_r[3:0]) + 5'($past(status_r[BIT_CARRY])) > 5'h0f)
	) else $error("half carry wrong");

	a_half_borrow: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_sub_req |=> status_r[BIT_HALF] == (5'($past(main_operand_reg_r[3:0]))
			< 5'($past(aux_mul_div_reg_r[3:0])) + 5'($past(status_r[BIT_CARRY])))
	) else $error("half borrow wrong");

	a_parity_track: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		##1 o_status_word[BIT_PARITY] == $past(^main_operand_reg_r)
	) else $error("parity wrong");

	a_status_reset: assert property (
		@(posedge i_core_clk) $fell(i_reset) |-> status_r == STATUS_RESET
	) else $error("status not zero after reset");

	a_status_write: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		(wr_status && op == OP_NONE) |=> status_r[7:1] == $past(req.dat[7:1])
	) else $error("status write lost");

	a_data_pointer_bytes: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		wr_dph |=> data_pointer_r == {$past(req.dat), $past(data_pointer_r[7:0])}
	) else $error("data_pointer high write wrong");

	a_data_pointer_step: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_data_pointer_inc_req |=> o_data_pointer == $past(o_data_pointer) + 16'h0001
	) else $error("data_pointer increment wrong");

	a_aux_write: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		wr_aux |=> aux_mul_div_reg_r == $past(req.dat)
	) else $error("aux write lost");

	a_div_zero: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_div_zero_req |=> status_r[BIT_EXCESS] && main_operand_reg_r == 8'hff
	) else $error("div zero overflow missing");

	a_add_excess: assert property (
		@(posedge i_core_clk) disable iff (i_reset)
		s_add_req |=> status_r[BIT_EXCESS] == (($past(main_operand_reg_r[7])
			== $past(aux_mul_div_reg_r[7]))
			&& (main_operand_reg_r[7] != $past(main_operand_reg_r[7])))
	) else $error("add overflow wrong");

endmodule

/* wb_master_model.sv */
// Classic Wishbone master standing in for the instruction decoder.
// Assumes a slave that acks one cycle after it takes a request.
`timescale 1ns/1ps

module wb_master_model (
	input wire logic i_clk,
	input wire logic i_ack,
	input wire logic [7:0] i_rdat,
	output logic o_cyc,
	output logic o_stb,
	output logic o_we,
	output logic o_sel,
	output logic [7:0] o_adr,
	output logic [7:0] o_dat
);
	initial begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we = 1'b0;
		o_sel = 1'b0;
		o_adr = 8'h00;
		o_dat = 8'h00;
	end

	// Request held until ack seen at an edge; released data is inverted, never left stale
	// Only the bench timeout ends a wait that never sees ack
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we <= w;
		o_sel <= 1'b1;
		o_adr <= a;
		o_dat <= d;
		do begin
			@(posedge i_clk);
		end while (i_ack !== 1'b1);
		q = i_rdat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		o_we <= 1'b0;
		o_dat <= ~d;
		@(posedge i_clk);
	endtask
endmodule

/* test_cpu_core_status_registers.sv */
// Self-checking bench for the core special register block.
// Assumes the Wishbone master model drives all bus inputs.
`timescale 1ns/1ps

module test_cpu_core_status_registers;
	import core_regs_pkg::*;
	// ********************************
	// Clock, reset, wiring
	// ********************************
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic cyc, stb, we, sel, ack;
	logic [7:0] adr, wdat, rdat, bank, sp, sw;
	logic [15:0] pc, dp;
	int error_cnt = 0;
	int n_tests = 0;
	int clk_cnt = 0;

	always #50 i_core_clk = ~i_core_clk;

	core_status_regs u_core_status_regs (.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .o_instr_counter(pc),
		.o_bank_base(bank), .o_stack_top_ptr(sp), .o_data_pointer(dp), .o_status_word(sw));

	wb_master_model u_wb_master_model (.i_clk(i_core_clk), .i_ack(ack), .i_rdat(rdat),
		.o_cyc(cyc), .o_stb(stb), .o_we(we), .o_sel(sel), .o_adr(adr), .o_dat(wdat));

	// ********************************
	// Shared tasks
	// ********************************
	task automatic end_of_test();
		$display("errors %0d tests %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_wb_master_model.xfer(1'b1, a, d, q);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_wb_master_model.xfer(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset();
		chk("counter", 16'h0000, pc);
		chk("stack", 16'h0007, {8'h00, sp});
		rdchk(ADDR_STATUS, 8'h00);
		rdchk(ADDR_AUX, 8'h00);
		rdchk(8'h90, 8'h00);
	endtask

	task automatic t_muldiv();
		wr(ADDR_MAIN_OP, 8'hff);
		wr(ADDR_AUX, 8'hff);
		wr(ADDR_OP_CTRL, 8'h03);
		rdchk(ADDR_MAIN_OP, 8'h01);
		rdchk(ADDR_AUX, 8'hfe);
		wr(ADDR_MAIN_OP, 8'h64);
		wr(ADDR_AUX, 8'h07);
		wr(ADDR_OP_CTRL, 8'h04);
		rdchk(ADDR_MAIN_OP, 8'h0e);
		rdchk(ADDR_AUX, 8'h02);
	endtask

	// Signed overflow with half carry on add, then borrow out of both nibbles
	task automatic t_flags();
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_MAIN_OP, 8'h7f);
		wr(ADDR_AUX, 8'h01);
		wr(ADDR_OP_CTRL, 8'h01);
		rdchk(ADDR_MAIN_OP, 8'h80);
		rdchk(ADDR_STATUS, 8'h45);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_MAIN_OP, 8'h00);
		wr(ADDR_OP_CTRL, 8'h02);
		rdchk(ADDR_MAIN_OP, 8'hff);
		rdchk(ADDR_STATUS, 8'hc0);
	endtask

	task automatic t_bank();
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_STATUS, 8'(i * 8));
			rdchk(ADDR_STATUS, 8'(i * 8));
			chk("bank", 16'(i * 8), {8'h00, bank});
		end
		wr(ADDR_STATUS, 8'hfe);
		rdchk(ADDR_STATUS, 8'hfe);
		wr(ADDR_STATUS, 8'h00);
	endtask

	task automatic t_parity();
		logic [7:0] v[6] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h80, 8'hfe};
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_MAIN_OP, v[i]);
			rdchk(ADDR_MAIN_OP, v[i]);
			chk("parity", {15'h0000, ^v[i]}, {15'h0000, sw[BIT_PARITY]});
		end
	endtask

	task automatic t_misc();
		wr(ADDR_DATA_POINTER_LOW, 8'hff);
		wr(ADDR_DATA_POINTER_HIGH, 8'h12);
		wr(ADDR_OP_CTRL, 8'h05);
		rdchk(ADDR_DATA_POINTER_LOW, 8'h00);
		rdchk(ADDR_DATA_POINTER_HIGH, 8'h13);
		chk("data_pointer", 16'h1300, dp);
		wr(ADDR_OP_CTRL, 8'h06);
		rdchk(ADDR_STACK_TOP, 8'h08);
		wr(ADDR_OP_CTRL, 8'h07);
		rdchk(ADDR_COUNTER_LOW, 8'h01);
		chk("counter", 16'h0001, pc);
		wr(ADDR_AUX, 8'ha5);
		rdchk(ADDR_AUX, 8'ha5);
	endtask

	// Divide by zero, product overflow, then a reset in mid-run
	task automatic t_corner();
		wr(ADDR_MAIN_OP, 8'h2a);
		wr(ADDR_AUX, 8'h00);
		wr(ADDR_OP_CTRL, 8'h04);
		rdchk(ADDR_MAIN_OP, 8'hff);
		rdchk(ADDR_AUX, 8'h2a);
		rdchk(ADDR_STATUS, 8'h04);
		wr(ADDR_MAIN_OP, 8'h10);
		wr(ADDR_AUX, 8'h10);
		wr(ADDR_OP_CTRL, 8'h03);
		rdchk(ADDR_MAIN_OP, 8'h00);
		rdchk(ADDR_AUX, 8'h01);
		@(posedge i_core_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		chk("stack", 16'h0007, {8'h00, sp});
		chk("counter", 16'h0000, pc);
		rdchk(ADDR_STATUS, 8'h00);
		rdchk(ADDR_AUX, 8'h00);
	endtask

	// ********************************
	// Main sequence and timeout
	// ********************************
	always @(posedge i_core_clk) begin
		clk_cnt++;
		if (clk_cnt == 3000) begin
			error_cnt++;
			end_of_test();
		end
	end

	initial begin
		repeat (10) @(posedge i_core_clk);
		i_reset <= 1'b0;
		t_reset();
		t_muldiv();
		t_flags();
		t_bank();
		t_parity();
		t_misc();
		t_corner();
		end_of_test();
	end
endmodule
